// ==== rtl/pair_trig_pkg.sv ====
package pair_trig_pkg;
   // Register byte offsets on the AXI4-Lite bus
   localparam logic [3:0] OFS_CTRL_A = 4'h0;
   localparam logic [3:0] OFS_CTRL_B = 4'h4;
   localparam logic [3:0] OFS_STATUS = 4'h8;
   // Field positions inside one byte-wide pair slot
   localparam int FLD_IRQ_EN = 7;
   localparam int FLD_PEND = 6;
   localparam int FLD_SOFT = 5;
   localparam int FLD_SEL_HI = 4;
   localparam int PAIR_SLOT = 8;
   localparam logic [15:0] CTRL_RESET = 16'h0000;
   localparam int NUM_PAIRS = 4;
   // Selector codes
   localparam logic [4:0] SEL_OFF = 5'h00;
   localparam logic [4:0] SEL_SOFT_OWN = 5'h01;
   localparam logic [4:0] SEL_SOFT_GLOBAL = 5'h02;
   localparam logic [4:0] SEL_SPECIAL = 5'h03;
   localparam logic [4:0] SEL_PRI_FIRST = 5'h04;
   localparam logic [4:0] SEL_PRI_LAST = 5'h07;
   localparam logic [4:0] SEL_TIMER_A = 5'h0C;
   localparam logic [4:0] SEL_SEC_FIRST = 5'h0E;
   localparam logic [4:0] SEL_SEC_LAST = 5'h11;
   localparam logic [4:0] SEL_LIM_FIRST = 5'h17;
   localparam logic [4:0] SEL_LIM_LAST = 5'h1A;
   localparam logic [4:0] SEL_TIMER_B = 5'h1F;
   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== rtl/trigger_source_mux.sv ====
`timescale 1ns/100ps
// Picks one trigger event out of the source set for a single pair
module trigger_source_mux
   import pair_trig_pkg::*;
(
   // Selection
   input wire logic [4:0] sel,
   input wire logic soft_own,
   input wire logic soft_global,
   // Event sources
   input wire logic special_evt,
   input wire logic [3:0] pri_evt,
   input wire logic [3:0] sec_evt,
   input wire logic [3:0] lim_evt,
   input wire logic timer_a_evt,
   input wire logic timer_b_evt,
   // Result
   output logic fire
);
   logic [1:0] idx;

   // Range codes index the generator, low two bits minus the base
   always_comb begin
      idx = 2'h0;
      fire = 1'b0;
      if (sel == SEL_SOFT_OWN) begin
         fire = soft_own;
      end else if (sel == SEL_SOFT_GLOBAL) begin
         fire = soft_global;
      end else if (sel == SEL_SPECIAL) begin
         fire = special_evt;
      end else if (sel >= SEL_PRI_FIRST && sel <= SEL_PRI_LAST) begin
         idx = 2'(sel - SEL_PRI_FIRST);
         fire = pri_evt[idx];
      end else if (sel >= SEL_SEC_FIRST && sel <= SEL_SEC_LAST) begin
         idx = 2'(sel - SEL_SEC_FIRST);
         fire = sec_evt[idx];
      end else if (sel >= SEL_LIM_FIRST && sel <= SEL_LIM_LAST) begin
         idx = 2'(sel - SEL_LIM_FIRST);
         fire = lim_evt[idx];
      end else if (sel == SEL_TIMER_A) begin
         fire = timer_a_evt;
      end else if (sel == SEL_TIMER_B) begin
         fire = timer_b_evt;
      end else begin
         fire = 1'b0; // Off, reserved and undefined codes
      end
   end
endmodule // trigger_source_mux

// ==== rtl/pair_trigger_control.sv ====
// Local design decisions: the AXI4-Lite register port and the register addresses.
`timescale 1ns/100ps
// Overview of operation
// - Selector 00000 off, 00001 own software trigger, 00010 global software.
// - 00011 special event; 00100-00111 primary trigger of generators 1-4.
// - 01110-10001 choose secondary trigger of generators 1-4.
// - 10111-11010 choose current-limit trigger of generators 1-4.
// - 01100 first timer period match; 11111 second timer period match.
// - Selected trigger sets the pair pending flag.
// - Pending clears once both inputs of the pair are converted.
// - Writing one to soft trigger requests conversion if selected.
// - Hardware clears soft trigger bit when it sets pending.
// - Enabled pair raises interrupt request on conversion completion.
// - Busy converter leaves request pending until resources free.
// - Pairs 2..5 convert inputs 5/4, 7/6, 9/8, 11/10.
// - Low pair uses bits 7,6,5 and 4-0; upper pair bits 15-8.
// - All fields reset to zero, conversion disabled.
// - Pair 3 enable, pending, soft trigger at bits 15, 14, 13.
module pair_trigger_control
   import pair_trig_pkg::*;
#(
   parameter int PAIRS = NUM_PAIRS
)
(
   // Clock, reset, enable
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clk_en,
   // AXI4-Lite write address
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Trigger events, one cycle wide, same clock
   input wire logic soft_global_evt,
   input wire logic special_evt,
   input wire logic [3:0] pri_evt,
   input wire logic [3:0] sec_evt,
   input wire logic [3:0] lim_evt,
   input wire logic timer_a_evt,
   input wire logic timer_b_evt,
   // Conversion core handshake, index 0 is pair 2
   output logic [PAIRS-1:0] conv_req,
   input wire logic [PAIRS-1:0] conv_grant,
   input wire logic [PAIRS-1:0] conv_done,
   // Interrupt requests toward the interrupt controller
   output logic [PAIRS-1:0] pair_irq
);
   // Byte slot per pair: pair 2,3 in ctrl_a, pair 4,5 in ctrl_b
   logic [4:0] sel_r [PAIRS];
   logic [PAIRS-1:0] irq_en_r;
   logic [PAIRS-1:0] pend_r;
   logic [PAIRS-1:0] soft_r;
   logic [PAIRS-1:0] busy_r;
   logic [PAIRS-1:0] fire;
   logic [PAIRS-1:0] conv_req_r;
   logic [PAIRS-1:0] pair_irq_r;

   // Bus slave state
   logic [3:0] awaddr_r;
   logic aw_held_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic w_held_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0] rresp_r;
   logic [31:0] rdata_nxt;
   logic wr_fire;
   logic wr_hit;
   logic [3:0] wr_base;

   // Pack one pair into its byte slot
   function automatic logic [7:0] slot(input int p);
      slot = {irq_en_r[p], pend_r[p], soft_r[p], sel_r[p]};
   endfunction

   // True when a byte address names a mapped register
   function automatic logic mapped(input logic [3:0] a);
      mapped = (a == OFS_CTRL_A) || (a == OFS_CTRL_B) || (a == OFS_STATUS);
   endfunction

   // A held write reaches pair p through its register and byte lane
   function automatic logic lane_hit(input int p);
      lane_hit = wr_fire && wr_hit && int'(wr_base) == (p & 2)
                 && wstrb_r[p & 1];
   endfunction

   // Bit position of a field of pair p inside the held write word
   function automatic int field_pos(input int p, input int f);
      field_pos = (p & 1) * PAIR_SLOT + f;
   endfunction

   generate
      for (genvar g = 0; g < PAIRS; g++) begin : g_mux
         trigger_source_mux u_mux (
            .sel(sel_r[g]),
            .soft_own(soft_r[g]),
            .soft_global(soft_global_evt),
            .special_evt(special_evt),
            .pri_evt(pri_evt),
            .sec_evt(sec_evt),
            .lim_evt(lim_evt),
            .timer_a_evt(timer_a_evt),
            .timer_b_evt(timer_b_evt),
            .fire(fire[g])
         );
      end
   endgenerate

   // Write fires once both address and data are held and no response waits
   assign wr_fire = aw_held_r && w_held_r && !bvalid_r;
   assign wr_hit = (awaddr_r == OFS_CTRL_A) || (awaddr_r == OFS_CTRL_B);
   assign wr_base = (awaddr_r == OFS_CTRL_B) ? 4'h2 : 4'h0;

   // Write address channel, taken independently of data
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         aw_held_r <= 1'b0;
         awaddr_r <= 4'h0;
      end else if (clk_en) begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
         end else if (wr_fire) begin
            aw_held_r <= 1'b0;
         end
      end
   end

   // Write data channel
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         w_held_r <= 1'b0;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
      end else if (clk_en) begin
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end else if (wr_fire) begin
            w_held_r <= 1'b0;
         end
      end
   end

   // Address ready is a flop so the output stays registered; it drops after
   // each take and stays low while the address is held or a response waits,
   // so a second write cannot slip in behind an unanswered one
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_awready <= 1'b0;
      end else if (clk_en) begin
         s_axi_awready <= !aw_held_r && !bvalid_r
                          && !(s_axi_awvalid && s_axi_awready);
      end
   end

   // Data ready follows the same pattern on its own channel
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_wready <= 1'b0;
      end else if (clk_en) begin
         s_axi_wready <= !w_held_r && !bvalid_r
                         && !(s_axi_wvalid && s_axi_wready);
      end
   end

   // Write response; unmapped or status writes answer SLVERR
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
      end else if (clk_en) begin
         if (wr_fire) begin
            bvalid_r <= 1'b1;
            bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (bvalid_r && s_axi_bready) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   // Selector per pair; the byte lane picks the pair
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int p = 0; p < PAIRS; p++) begin
            sel_r[p] <= CTRL_RESET[FLD_SEL_HI:0];
         end
      end else if (clk_en) begin
         for (int p = 0; p < PAIRS; p++) begin
            if (lane_hit(p)) begin
               sel_r[p] <= wdata_r[field_pos(p, 0) +: 5];
            end
         end
      end
   end

   // Interrupt enable per pair, same lane decode
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_en_r <= '0;
      end else if (clk_en) begin
         for (int p = 0; p < PAIRS; p++) begin
            if (lane_hit(p)) begin
               irq_en_r[p] <= wdata_r[field_pos(p, FLD_IRQ_EN)];
            end
         end
      end
   end

   // Soft trigger: set by a write of one, cleared whenever it fires.
   // Clearing even while pending stops a held bit re-arming forever.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         soft_r <= '0;
      end else if (clk_en) begin
         for (int p = 0; p < PAIRS; p++) begin
            if (fire[p]) begin
               soft_r[p] <= 1'b0;
            end else if (lane_hit(p) && wdata_r[field_pos(p, FLD_SOFT)]) begin
               soft_r[p] <= 1'b1;
            end
         end
      end
   end

   // Pending flag: trigger sets, completion clears; set wins a tie.
   // Triggers while pending merge into the outstanding request.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pend_r <= '0;
      end else if (clk_en) begin
         for (int p = 0; p < PAIRS; p++) begin
            if (fire[p]) begin
               pend_r[p] <= 1'b1;
            end else if (conv_done[p] && busy_r[p]) begin
               pend_r[p] <= 1'b0;
            end
         end
      end
   end

   // Request to the core is held while pending and not yet granted.
   // The core grants when its resources are free; we simply wait.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_r <= '0;
         conv_req_r <= '0;
      end else if (clk_en) begin
         for (int p = 0; p < PAIRS; p++) begin
            if (conv_done[p] && busy_r[p]) begin
               busy_r[p] <= 1'b0;
            end else if (conv_req_r[p] && conv_grant[p]) begin
               busy_r[p] <= 1'b1;
            end
            conv_req_r[p] <= (pend_r[p] || fire[p]) && !busy_r[p]
                             && !(conv_req_r[p] && conv_grant[p]);
         end
      end
   end

   // Interrupt request: one-cycle pulse on completion when enabled
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pair_irq_r <= '0;
      end else if (clk_en) begin
         pair_irq_r <= conv_done & busy_r & irq_en_r;
      end
   end

   // Read ready drops after a take and until the answer is taken
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b0;
      end else if (clk_en) begin
         s_axi_arready <= !rvalid_r && !(s_axi_arvalid && s_axi_arready);
      end
   end

   // Read answer one cycle after the take; unmapped words answer SLVERR
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rvalid_r <= 1'b0;
         rresp_r <= RESP_OKAY;
      end else if (clk_en) begin
         if (s_axi_arvalid && s_axi_arready) begin
            rvalid_r <= 1'b1;
            rresp_r <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
         end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
         end
      end
   end

   // Word selected by the read address; unmapped words read zero
   always_comb begin
      rdata_nxt = 32'h0000_0000;
      case (s_axi_araddr)
         OFS_CTRL_A: rdata_nxt = {16'h0000, slot(1), slot(0)};
         OFS_CTRL_B: rdata_nxt = {16'h0000, slot(3), slot(2)};
         OFS_STATUS: rdata_nxt = {24'h00_0000, busy_r, pend_r};
         default: rdata_nxt = 32'h0000_0000;
      endcase
   end

   // Read data is captured at the take and stands until the next one
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_r <= 32'h0000_0000;
      end else if (clk_en && s_axi_arvalid && s_axi_arready) begin
         rdata_r <= rdata_nxt;
      end
   end

   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;
   assign conv_req = conv_req_r;
   assign pair_irq = pair_irq_r;
endmodule // pair_trigger_control

// ==== sim/conv_core_model.sv ====
`timescale 1ns/100ps
// One shared converter: a later pair waits until the current one is done
module conv_core_model #(
   parameter int LAT = 8
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Handshake toward the trigger control
   input wire logic [3:0] conv_req,
   output logic [3:0] conv_grant,
   output logic [3:0] conv_done
);
   logic [3:0] cnt_r;
   logic [3:0] own_r;
   logic busy_r;

   // Grant the lowest request after LAT cycles, finish LAT+2 cycles after the grant
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= 4'h0;
         own_r <= 4'h0;
         busy_r <= 1'b0;
         conv_grant <= 4'h0;
         conv_done <= 4'h0;
      end else begin
         conv_grant <= 4'h0;
         conv_done <= 4'h0;
         if (conv_grant != 4'h0 || (!busy_r && conv_req == 4'h0)) begin
            cnt_r <= 4'h0;
         end else if (cnt_r != LAT[3:0]) begin
            cnt_r <= cnt_r + 4'h1;
         end else if (!busy_r) begin
            own_r <= conv_req & (~conv_req + 4'h1);
            conv_grant <= conv_req & (~conv_req + 4'h1);
            busy_r <= 1'b1;
         end else begin
            conv_done <= own_r;
            busy_r <= 1'b0;
            cnt_r <= 4'h0;
         end
      end
   end
endmodule // conv_core_model

// ==== sim/pair_trigger_control_sva.sv ====
`timescale 1ns/100ps
// Port-level checks; frozen cycles are skipped since state holds then
module pair_trigger_control_sva
   import pair_trig_pkg::*;
#(
   parameter int PAIRS = NUM_PAIRS
)
(
   // Clock, reset, enable
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clk_en,
   // Bus handshakes
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   // Conversion handshake and interrupts
   input wire logic [PAIRS-1:0] conv_req,
   input wire logic [PAIRS-1:0] conv_grant,
   input wire logic [PAIRS-1:0] conv_done,
   input wire logic [PAIRS-1:0] pair_irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n || !clk_en);

   // Bus takes
   sequence wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence

   chk_write_answer: assert property (wr_taken |-> ##2 s_axi_bvalid)
      else $error("write response missing");
   chk_read_answer: assert property (rd_taken |=> s_axi_rvalid)
      else $error("read data missing");
   chk_write_refuse: assert property (s_axi_bvalid |-> !s_axi_awready)
      else $error("address taken while response pending");
   chk_req_hold: assert property (1'b1 |=>
      ($past(conv_req) & ~$past(conv_grant) & ~conv_req) == '0)
      else $error("request dropped without grant");
   chk_req_drop: assert property (1'b1 |=>
      ($past(conv_req & conv_grant) & conv_req) == '0)
      else $error("request kept after grant");
   chk_irq_cause: assert property ((pair_irq & ~$past(conv_done)) == '0)
      else $error("interrupt without completion");
   chk_irq_pulse: assert property ((pair_irq & $past(pair_irq)) == '0)
      else $error("interrupt longer than one cycle");
   chk_reset_clear: assert property ($rose(rst_n) |->
      conv_req == '0 && pair_irq == '0)
      else $error("outputs active after reset");
endmodule // pair_trigger_control_sva

bind pair_trigger_control pair_trigger_control_sva #(.PAIRS(PAIRS))
   pair_trigger_control_sva_i (.clk, .rst_n, .clk_en, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .conv_req, .conv_grant,
   .conv_done, .pair_irq);

// ==== sim/pair_trigger_control_tb.sv ====
`timescale 1ns/100ps
module pair_trigger_control_tb;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [3:0] s_axi_awaddr = 4'h0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic [3:0] s_axi_araddr = 4'h0;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_rready = 1'b0;
   logic [15:0] ev = 16'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic [3:0] conv_req, conv_grant, conv_done, pair_irq;
   int miscompares = 0;
   int checks = 0;
   int cyc = 0;

   // 50 MHz clock
   initial begin
      forever #10 clk = ~clk;
   end

   // Events packed low to high: global, special, pri, sec, lim, timers
   pair_trigger_control pair_trigger_control_i (.clk, .rst_n,
      .clk_en(1'b1), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .soft_global_evt(ev[0]),
      .special_evt(ev[1]), .pri_evt(ev[5:2]), .sec_evt(ev[9:6]),
      .lim_evt(ev[13:10]), .timer_a_evt(ev[14]), .timer_b_evt(ev[15]),
      .conv_req, .conv_grant, .conv_done, .pair_irq);
   conv_core_model conv_core_model_i (.clk, .rst_n, .conv_req, .conv_grant,
      .conv_done);

   task automatic end_sim;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Beats are dropped as taken; bready stays up until bvalid is seen
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
      input logic [3:0] s, output logic [1:0] r);
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   task automatic axi_rd(input logic [3:0] a, output logic [31:0] d,
      output logic [1:0] r);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   // One-cycle event pulse on the selected sources
   task automatic pulse(input logic [15:0] v);
      @(posedge clk);
      ev <= v;
      @(posedge clk);
      ev <= 16'h0;
   endtask

   // Source expected for a selector code; zero where none may fire
   function automatic logic [15:0] src(input logic [4:0] c);
      case (c) inside
         5'h02: src = 16'h0001;
         5'h03: src = 16'h0002;
         [5'h04:5'h07]: src = 16'h0004 << (c - 5'h04);
         [5'h0E:5'h11]: src = 16'h0040 << (c - 5'h0E);
         [5'h17:5'h1A]: src = 16'h0400 << (c - 5'h17);
         5'h0C: src = 16'h4000;
         5'h1F: src = 16'h8000;
         default: src = 16'h0000;
      endcase
   endfunction

   task automatic t_regs;
      logic [31:0] d;
      logic [1:0] r;
      axi_rd(4'h0, d, r);
      cmp(d, 32'h0);
      cmp(r, 2'h0);
      axi_wr(4'h4, 32'h4040, 4'h3, r);
      cmp(r, 2'h0);
      axi_rd(4'h4, d, r);
      cmp(d, 32'h0);
      axi_wr(4'h8, 32'h1, 4'hF, r);
      cmp(r, 2'h2);
      axi_rd(4'hC, d, r);
      cmp({d[29:0], r}, 32'h2);
      $display("t_regs done");
   endtask

   // Every code: all other sources first, then its own one
   task automatic t_codes;
      logic [31:0] d;
      logic [1:0] r;
      logic [4:0] c;
      logic [15:0] s;
      logic want;
      for (int i = 0; i < 32; i++) begin
         c = i[4:0];
         s = src(c);
         want = (c == 5'h01) || (s != 16'h0);
         axi_wr(4'h0, {24'h0, c[0], 2'b00, c}, 4'h1, r);
         pulse(~s);
         @(posedge clk);
         cmp(conv_req[0], 1'b0);
         if (c == 5'h01) axi_wr(4'h0, 32'hA1, 4'h1, r);
         else pulse(s);
         @(posedge clk);
         cmp(conv_req[0], want);
         if (want) begin
            do @(posedge clk); while (!conv_done[0]);
            @(posedge clk);
            cmp(pair_irq[0], c[0]);
            axi_rd(4'h0, d, r);
            cmp(d, {24'h0, c[0], 2'b00, c});
         end
      end
      $display("t_codes done");
   endtask

   // Three pairs at once share one converter
   task automatic t_pairs;
      logic [31:0] d;
      logic [1:0] r;
      logic [3:0] seen;
      seen = 4'h0;
      axi_wr(4'h0, 32'h2100, 4'h2, r);
      axi_wr(4'h4, 32'hA1A1, 4'h3, r);
      @(posedge clk);
      cmp(conv_req, 4'hE);
      repeat (120) begin
         @(posedge clk);
         seen |= pair_irq;
      end
      cmp(seen, 4'hC);
      axi_rd(4'h4, d, r);
      cmp(d, 32'h8181);
      axi_rd(4'h0, d, r);
      cmp(d, 32'h019F);
      $display("t_pairs done");
   endtask

   // Watchdog far above the expected run length
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         miscompares++;
         end_sim;
      end
   end

   // Main sequence
   initial begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      t_regs;
      t_codes;
      t_pairs;
      end_sim;
   end
endmodule // pair_trigger_control_tb
